/* File: rtl/pfr_pkg.sv */
package pfr_pkg;
  typedef logic signed [15:0] pfr_val_t;
  typedef logic signed [33:0] pfr_wide_t;

  typedef struct packed {
    logic drive;
    logic mod_en;
    logic ratio_lock;
    logic inv_pol;
    logic linear_mode;
    logic enable;
  } pfr_ctrl_s;

  typedef struct packed {
    pfr_ctrl_s ctrl;
    logic [3:0] in_sel;
    logic [1:0] out_sel;
    pfr_val_t min_v;
    pfr_val_t max_v;
    pfr_val_t kp;
    pfr_val_t ki;
    pfr_val_t setp;
    pfr_val_t gain;
    pfr_val_t offs;
    pfr_val_t mod_amp;
  } pfr_sect_s;

  // value of linear_mode that selects the feedback loop
  localparam logic MODE_PROP_INTEGRAL = 1'b0;

  // source indices; coefficient units follow the source
  // (frequency shift: V/Hz, phase: V/deg and V/deg/s)
  localparam logic [3:0] SRC_ADC = 4'h0;
  localparam logic [3:0] SRC_HF_FREQUENCY_SHIFT_INPUT = 4'h1;
  localparam logic [3:0] SRC_HF_AMPL = 4'h2;
  localparam logic [3:0] SRC_HF_PHASE_INPUT = 4'h3;
  localparam logic [3:0] SRC_LOWFREQ_DEMOD_AMPLITUDE = 4'h4;
  localparam logic [3:0] SRC_LF_PHASE = 4'h5;

  localparam logic [7:0] SECT_STRIDE = 8'h40;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_SEL = 6'h04;
  localparam logic [5:0] OFF_OUT = 6'h08;
  localparam logic [5:0] OFF_MIN = 6'h0C;
  localparam logic [5:0] OFF_MAX = 6'h10;
  localparam logic [5:0] OFF_KP = 6'h14;
  localparam logic [5:0] OFF_KI = 6'h18;
  localparam logic [5:0] OFF_SETP = 6'h1C;
  localparam logic [5:0] OFF_GAIN = 6'h20;
  localparam logic [5:0] OFF_OFFS = 6'h24;
  localparam logic [5:0] OFF_MODA = 6'h28;
  localparam logic [7:0] ADDR_STATIC = 8'h80;
  localparam logic [7:0] ADDR_LIMIT = 8'h90;
  localparam logic [7:0] ADDR_LFMOD = 8'hA0;

  localparam int CTRL_RESET_BIT = 8;
  localparam int STAT_CLAMP_HI_BIT = 16;
  localparam int STAT_CLAMP_LO_BIT = 17;
  localparam int SEL_OUT_POS = 8;

  localparam int P_SHIFT = 8;
  localparam int I_SHIFT = 12;
  localparam int G_SHIFT = 8;
  localparam int LF_SHIFT = 8;
  localparam int MOD_HALF_CYCLES = 1000;

  localparam pfr_val_t START_VALUE = 16'h0000;
  localparam pfr_val_t MIN_RESET = 16'h8000;
  localparam pfr_val_t MAX_RESET = 16'h7FFF;
  localparam pfr_sect_s SECT_RESET = '{
    ctrl: 6'h00, in_sel: 4'h0, out_sel: 2'h0,
    min_v: MIN_RESET, max_v: MAX_RESET, kp: 16'h0000,
    ki: 16'h0000, setp: 16'h0000, gain: 16'h0100,
    offs: 16'h0000, mod_amp: 16'h0000};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pfr_pkg

/* File: rtl/pfr_router.sv */
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - two independent sections, each feedback loop or linear router
// - each section picks any input source and any of four outputs
// - disabling a section keeps its last output value
// - reset command forces the section output to a start value
// - enabled: output reads live; stopped: written output drives channel
// - a driving section overrides the channel's static voltage
// - section output clamped between programmable minimum and maximum
// - ratio lock rescales the other coefficient to keep P/I ratio
// - feedback mode regulates the input toward a target value
// - normal polarity: output falls when input exceeds target
// - inverted polarity reverses the correction direction
// - target value can be modulated with a square wave
// - linear mode multiplies the input by a programmable gain
// - linear mode adds a programmable offset
// - coefficient units depend on the selected input source
// - one static voltage register per output channel
// - static voltage confined to its channel's limit range
// - static voltage may be modulated by the low-frequency demodulator
module pfr_router #(
  parameter int NSRC = 6,
  parameter int NCH = 4,
  parameter int MOD_HALF = pfr_pkg::MOD_HALF_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0][15:0] src_sig,
  input wire logic [15:0] lowfreq_demod_amplitude,
  output logic [NCH-1:0][15:0] dac_out
);
  typedef logic signed [33:0] wide_t;

  function automatic pfr_pkg::pfr_val_t clamp(
    input wide_t v,
    input pfr_pkg::pfr_val_t lo,
    input pfr_pkg::pfr_val_t hi
  );
    if (v > wide_t'(hi)) begin
      clamp = hi;
    end else if (v < wide_t'(lo)) begin
      clamp = lo;
    end else begin
      clamp = v[15:0];
    end
  endfunction : clamp

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (a < pfr_pkg::ADDR_STATIC) begin
      mapped = a[5:0] <= pfr_pkg::OFF_MODA;
    end else begin
      mapped = a < pfr_pkg::ADDR_LFMOD + 8'h04;
    end
  endfunction : mapped

  // other * new / old, saturated; old of zero leaves other alone
  function automatic pfr_pkg::pfr_val_t rescale(
    input pfr_pkg::pfr_val_t other,
    input pfr_pkg::pfr_val_t nw,
    input pfr_pkg::pfr_val_t old
  );
    logic signed [31:0] prod;
    logic signed [31:0] q;
    prod = other * nw;
    q = (old == 16'sh0000) ? 32'(other) : prod / 32'(old);
    rescale = clamp(wide_t'(q), pfr_pkg::MIN_RESET, pfr_pkg::MAX_RESET);
  endfunction : rescale

  // input synchronisers
  logic [NSRC-1:0][15:0] src_s1_reg;
  logic [NSRC-1:0][15:0] src_s2_reg;
  logic [15:0] lf_s1_reg;
  logic [15:0] lf_s2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
      lf_s1_reg <= 16'h0000;
      lf_s2_reg <= 16'h0000;
    end else begin
      src_s1_reg <= src_sig;
      src_s2_reg <= src_s1_reg;
      lf_s1_reg <= lowfreq_demod_amplitude;
      lf_s2_reg <= lf_s1_reg;
    end
  end

  // axi write channel
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pfr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(waddr_reg) ? pfr_pkg::RESP_OKAY
                                         : pfr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage
  pfr_pkg::pfr_sect_s cfg_reg [2];
  pfr_pkg::pfr_val_t stat_reg [NCH];
  pfr_pkg::pfr_val_t lim_min_reg [NCH];
  pfr_pkg::pfr_val_t lim_max_reg [NCH];
  logic [NCH-1:0] lf_en_reg;
  pfr_pkg::pfr_val_t lf_depth_reg;
  pfr_pkg::pfr_val_t out_reg [2];
  logic [1:0] clamp_hi_reg;
  logic [1:0] clamp_lo_reg;

  logic wr_sect;
  logic wsel;
  logic [5:0] woff;
  logic [1:0] wch;
  logic [31:0] wword;
  assign wr_sect = wr_fire && waddr_reg < pfr_pkg::ADDR_STATIC
                   && waddr_reg[1:0] == 2'h0;
  assign wsel = waddr_reg[6];
  assign woff = waddr_reg[5:0];
  assign wch = waddr_reg[3:2];

  always_comb begin
    wword = 32'h0000_0000;
    if (waddr_reg < pfr_pkg::ADDR_STATIC) begin
      unique case (woff)
        pfr_pkg::OFF_CTRL: wword = {24'h000000, 2'h0, cfg_reg[wsel].ctrl};
        pfr_pkg::OFF_SEL: wword = {22'h000000, cfg_reg[wsel].out_sel,
                                   4'h0, cfg_reg[wsel].in_sel};
        pfr_pkg::OFF_OUT: wword = {16'h0000, out_reg[wsel]};
        pfr_pkg::OFF_MIN: wword = {16'h0000, cfg_reg[wsel].min_v};
        pfr_pkg::OFF_MAX: wword = {16'h0000, cfg_reg[wsel].max_v};
        pfr_pkg::OFF_KP: wword = {16'h0000, cfg_reg[wsel].kp};
        pfr_pkg::OFF_KI: wword = {16'h0000, cfg_reg[wsel].ki};
        pfr_pkg::OFF_SETP: wword = {16'h0000, cfg_reg[wsel].setp};
        pfr_pkg::OFF_GAIN: wword = {16'h0000, cfg_reg[wsel].gain};
        pfr_pkg::OFF_OFFS: wword = {16'h0000, cfg_reg[wsel].offs};
        pfr_pkg::OFF_MODA: wword = {16'h0000, cfg_reg[wsel].mod_amp};
        default: wword = 32'h0000_0000;
      endcase
    end else if (waddr_reg < pfr_pkg::ADDR_LIMIT) begin
      wword = {16'h0000, stat_reg[wch]};
    end else if (waddr_reg < pfr_pkg::ADDR_LFMOD) begin
      wword = {lim_max_reg[wch], lim_min_reg[wch]};
    end else begin
      wword = {lf_depth_reg, 12'h000, lf_en_reg};
    end
    wword = merge(wword, wdata_reg, wstrb_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg[0] <= pfr_pkg::SECT_RESET;
      cfg_reg[1] <= pfr_pkg::SECT_RESET;
    end else if (wr_sect) begin
      unique case (woff)
        pfr_pkg::OFF_CTRL: cfg_reg[wsel].ctrl <= wword[5:0];
        pfr_pkg::OFF_SEL: begin
          cfg_reg[wsel].in_sel <= wword[3:0];
          cfg_reg[wsel].out_sel <= wword[pfr_pkg::SEL_OUT_POS +: 2];
        end
        pfr_pkg::OFF_MIN: cfg_reg[wsel].min_v <= wword[15:0];
        pfr_pkg::OFF_MAX: cfg_reg[wsel].max_v <= wword[15:0];
        pfr_pkg::OFF_KP: begin
          cfg_reg[wsel].kp <= wword[15:0];
          if (cfg_reg[wsel].ctrl.ratio_lock) begin
            cfg_reg[wsel].ki <= rescale(cfg_reg[wsel].ki, wword[15:0],
                                        cfg_reg[wsel].kp);
          end
        end
        pfr_pkg::OFF_KI: begin
          cfg_reg[wsel].ki <= wword[15:0];
          if (cfg_reg[wsel].ctrl.ratio_lock) begin
            cfg_reg[wsel].kp <= rescale(cfg_reg[wsel].kp, wword[15:0],
                                        cfg_reg[wsel].ki);
          end
        end
        pfr_pkg::OFF_SETP: cfg_reg[wsel].setp <= wword[15:0];
        pfr_pkg::OFF_GAIN: cfg_reg[wsel].gain <= wword[15:0];
        pfr_pkg::OFF_OFFS: cfg_reg[wsel].offs <= wword[15:0];
        pfr_pkg::OFF_MODA: cfg_reg[wsel].mod_amp <= wword[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NCH; c++) begin
        stat_reg[c] <= 16'h0000;
        lim_min_reg[c] <= pfr_pkg::MIN_RESET;
        lim_max_reg[c] <= pfr_pkg::MAX_RESET;
      end
      lf_en_reg <= '0;
      lf_depth_reg <= 16'h0000;
    end else if (wr_fire && waddr_reg[1:0] == 2'h0) begin
      if (waddr_reg >= pfr_pkg::ADDR_STATIC
          && waddr_reg < pfr_pkg::ADDR_LIMIT) begin
        stat_reg[wch] <= clamp(wide_t'($signed(wword[15:0])),
                               lim_min_reg[wch], lim_max_reg[wch]);
      end else if (waddr_reg >= pfr_pkg::ADDR_LIMIT
                   && waddr_reg < pfr_pkg::ADDR_LFMOD) begin
        lim_min_reg[wch] <= wword[15:0];
        lim_max_reg[wch] <= wword[31:16];
      end else if (waddr_reg == pfr_pkg::ADDR_LFMOD) begin
        lf_en_reg <= wword[NCH-1:0];
        lf_depth_reg <= wword[31:16];
      end
    end
  end

  // setpoint modulation square wave
  logic [31:0] mod_cnt_reg;
  logic mod_ph_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_cnt_reg <= 32'h0000_0000;
      mod_ph_reg <= 1'b0;
    end else if (mod_cnt_reg == 32'(MOD_HALF - 1)) begin
      mod_cnt_reg <= 32'h0000_0000;
      mod_ph_reg <= !mod_ph_reg;
    end else begin
      mod_cnt_reg <= mod_cnt_reg + 32'h0000_0001;
    end
  end

  // two transfer sections
  for (genvar s = 0; s < 2; s++) begin : g_sect
    pfr_pkg::pfr_sect_s c;
    pfr_pkg::pfr_val_t x;
    wide_t sp;
    wide_t err;
    wide_t pterm;
    wide_t iinc;
    wide_t raw;
    wide_t lin;
    wide_t integ_reg;
    logic hit;
    logic rst_cmd;
    logic out_wr;
    assign c = cfg_reg[s];
    assign hit = wr_sect && wsel == 1'(s);
    assign rst_cmd = hit && woff == pfr_pkg::OFF_CTRL
                     && wword[pfr_pkg::CTRL_RESET_BIT];
    assign out_wr = hit && woff == pfr_pkg::OFF_OUT && !c.ctrl.enable;
    assign x = (32'(c.in_sel) < NSRC) ? src_s2_reg[c.in_sel]
                                      : 16'h0000;
    assign sp = wide_t'(c.setp) + (!c.ctrl.mod_en ? wide_t'(0) :
                mod_ph_reg ? wide_t'(c.mod_amp)
                           : -wide_t'(c.mod_amp));
    assign err = c.ctrl.inv_pol ? wide_t'(x) - sp
                                : sp - wide_t'(x);
    assign pterm = (wide_t'(c.kp) * err) >>> pfr_pkg::P_SHIFT;
    assign iinc = (wide_t'(c.ki) * err) >>> pfr_pkg::I_SHIFT;
    assign raw = pterm + integ_reg + iinc;
    assign lin = ((wide_t'(c.gain) * wide_t'(x)) >>> pfr_pkg::G_SHIFT)
                 + wide_t'(c.offs);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_reg[s] <= pfr_pkg::START_VALUE;
        integ_reg <= wide_t'(pfr_pkg::START_VALUE);
        clamp_hi_reg[s] <= 1'b0;
        clamp_lo_reg[s] <= 1'b0;
      end else if (rst_cmd) begin
        out_reg[s] <= clamp(wide_t'(pfr_pkg::START_VALUE),
                            c.min_v, c.max_v);
        integ_reg <= wide_t'(pfr_pkg::START_VALUE);
      end else if (out_wr) begin
        out_reg[s] <= clamp(wide_t'($signed(wword[15:0])),
                            c.min_v, c.max_v);
        integ_reg <= wide_t'($signed(wword[15:0]));
      end else if (c.ctrl.enable) begin
        if (c.ctrl.linear_mode == pfr_pkg::MODE_PROP_INTEGRAL) begin
          out_reg[s] <= clamp(raw, c.min_v, c.max_v);
          clamp_hi_reg[s] <= raw > wide_t'(c.max_v);
          clamp_lo_reg[s] <= raw < wide_t'(c.min_v);
          if (!((raw > wide_t'(c.max_v) && iinc > 0)
                || (raw < wide_t'(c.min_v) && iinc < 0))) begin
            integ_reg <= integ_reg + iinc;
          end
        end else begin
          out_reg[s] <= clamp(lin, c.min_v, c.max_v);
          clamp_hi_reg[s] <= lin > wide_t'(c.max_v);
          clamp_lo_reg[s] <= lin < wide_t'(c.min_v);
          integ_reg <= wide_t'(clamp(lin, c.min_v, c.max_v));
        end
      end
      // disabled: out_reg keeps its last value
    end
  end

  // channel outputs: driving section wins over static
  for (genvar ch = 0; ch < NCH; ch++) begin : g_dac
    wide_t lfterm;
    assign lfterm = lf_en_reg[ch]
      ? (wide_t'(lf_depth_reg) * wide_t'($signed(lf_s2_reg)))
        >>> pfr_pkg::LF_SHIFT
      : wide_t'(0);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dac_out[ch] <= 16'h0000;
      end else if (cfg_reg[0].ctrl.drive
                   && cfg_reg[0].out_sel == 2'(ch)) begin
        dac_out[ch] <= out_reg[0];
      end else if (cfg_reg[1].ctrl.drive
                   && cfg_reg[1].out_sel == 2'(ch)) begin
        dac_out[ch] <= out_reg[1];
      end else begin
        dac_out[ch] <= clamp(wide_t'(stat_reg[ch]) + lfterm,
                             lim_min_reg[ch], lim_max_reg[ch]);
      end
    end
  end

  // axi read channel
  logic [31:0] rword;
  logic rsel;
  logic [1:0] rch;
  assign rsel = s_axi_araddr[6];
  assign rch = s_axi_araddr[3:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rword = 32'h0000_0000;
    if (!mapped(s_axi_araddr)) begin
      rword = 32'h0000_0000;
    end else if (s_axi_araddr < pfr_pkg::ADDR_STATIC) begin
      unique case (s_axi_araddr[5:0])
        pfr_pkg::OFF_CTRL: begin
          rword[5:0] = cfg_reg[rsel].ctrl;
          rword[pfr_pkg::STAT_CLAMP_HI_BIT] = clamp_hi_reg[rsel];
          rword[pfr_pkg::STAT_CLAMP_LO_BIT] = clamp_lo_reg[rsel];
        end
        pfr_pkg::OFF_SEL: rword = {22'h000000, cfg_reg[rsel].out_sel,
                                   4'h0, cfg_reg[rsel].in_sel};
        pfr_pkg::OFF_OUT: rword = {16'h0000, out_reg[rsel]};
        pfr_pkg::OFF_MIN: rword = {16'h0000, cfg_reg[rsel].min_v};
        pfr_pkg::OFF_MAX: rword = {16'h0000, cfg_reg[rsel].max_v};
        pfr_pkg::OFF_KP: rword = {16'h0000, cfg_reg[rsel].kp};
        pfr_pkg::OFF_KI: rword = {16'h0000, cfg_reg[rsel].ki};
        pfr_pkg::OFF_SETP: rword = {16'h0000, cfg_reg[rsel].setp};
        pfr_pkg::OFF_GAIN: rword = {16'h0000, cfg_reg[rsel].gain};
        pfr_pkg::OFF_OFFS: rword = {16'h0000, cfg_reg[rsel].offs};
        pfr_pkg::OFF_MODA: rword = {16'h0000, cfg_reg[rsel].mod_amp};
        default: rword = 32'h0000_0000;
      endcase
    end else if (s_axi_araddr < pfr_pkg::ADDR_LIMIT) begin
      rword = {16'h0000, stat_reg[rch]};
    end else if (s_axi_araddr < pfr_pkg::ADDR_LFMOD) begin
      rword = {lim_max_reg[rch], lim_min_reg[rch]};
    end else begin
      rword = {lf_depth_reg, 12'h000, lf_en_reg};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pfr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rword;
      s_axi_rresp <= mapped(s_axi_araddr) ? pfr_pkg::RESP_OKAY
                                          : pfr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pfr_router

/* File: dv/pfr_checker.sv */
`timescale 1ns/1ns
module pfr_checker #(
  parameter int NSRC = 6,
  parameter int NCH = 4,
  parameter int MOD_HALF = pfr_pkg::MOD_HALF_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0][15:0] src_sig,
  input wire logic [15:0] lowfreq_demod_amplitude,
  input wire logic [NCH-1:0][15:0] dac_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> dac_out == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    !s_axi_bvalid |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_gate: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_bresp_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_rvalid_clear: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  a_addr_held: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address accepted while one held");
  a_err_data: assert property (
    s_axi_rvalid && s_axi_rresp == pfr_pkg::RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("error read returned data");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : pfr_checker

bind pfr_router pfr_checker #(.NSRC(NSRC), .NCH(NCH),
  .MOD_HALF(MOD_HALF)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .src_sig(src_sig),
  .lowfreq_demod_amplitude(lowfreq_demod_amplitude), .dac_out(dac_out));

/* File: dv/pfr_plant.sv */
`timescale 1ns/1ns
module pfr_plant #(
  parameter int NSRC = 6
) (
  input wire logic aclk,
  input wire logic [3:0][15:0] dac_out,
  input wire logic [NSRC-1:0][15:0] ext,
  input wire logic loop_on,
  output logic [NSRC-1:0][15:0] src_sig = '0
);
  // source 0 follows channel 3 with one cycle of lag when looped
  always @(posedge aclk) begin
    src_sig <= ext;
    if (loop_on) src_sig[0] <= dac_out[3];
  end
endmodule : pfr_plant

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0][15:0] src_sig;
  logic [5:0][15:0] ext = '0;
  logic loop_on = 1'b0;
  logic [15:0] lf_amp = 16'h0000;
  logic [3:0][15:0] dac_out;
  logic [15:0] lo, hi;
  int error_cnt = 0, checks = 0, cyc = 0;

  pfr_router #(.MOD_HALF(10)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_sig(src_sig),
    .lowfreq_demod_amplitude(lf_amp), .dac_out(dac_out));
  pfr_plant #(.NSRC(6)) plant (.aclk(aclk), .dac_out(dac_out),
    .ext(ext), .loop_on(loop_on), .src_sig(src_sig));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task wrap_up;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  task chk_range(input logic [15:0] got, input logic [15:0] lo_v,
                 input logic [15:0] hi_v);
    checks++;
    if (got >= lo_v && got <= hi_v) return;
    error_cnt++;
    $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo_v,
             hi_v);
  endtask : chk_range

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk_resp(bresp, er);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    chk(rdata, exp);
    chk_resp(rresp, er);
  endtask : rd

  initial begin
    tick(20);
    aresetn <= 1'b1;
    rd(8'h0C, 32'h8000, 2'h0);
    rd(8'h10, 32'h7FFF, 2'h0);
    rd(8'h20, 32'h0100, 2'h0);
    rd(8'hFC, 32'h0, 2'h2);
    wr(8'h02, 32'h1, 2'h2);
    wr(8'h94, 32'h1000F000, 2'h0);
    wr(8'h84, 32'h2000, 2'h0);
    rd(8'h84, 32'h1000, 2'h0);
    tick(4);
    chk({16'h0, dac_out[1]}, 32'h1000);
    lf_amp <= 16'h0100;
    wr(8'h80, 32'h0100, 2'h0);
    wr(8'hA0, 32'h01000001, 2'h0);
    tick(6);
    chk({16'h0, dac_out[0]}, 32'h0200);
    // section 0: linear router, source 2 to channel 2
    ext[2] <= 16'h0100;
    wr(8'h88, 32'h0055, 2'h0);
    wr(8'h04, 32'h0202, 2'h0);
    wr(8'h20, 32'h0200, 2'h0);
    wr(8'h24, 32'h0010, 2'h0);
    wr(8'h00, 32'h0023, 2'h0);
    tick(8);
    rd(8'h08, 32'h0210, 2'h0);
    chk({16'h0, dac_out[2]}, 32'h0210);
    wr(8'h10, 32'h0100, 2'h0);
    tick(4);
    rd(8'h00, 32'h00010023, 2'h0);
    chk({16'h0, dac_out[2]}, 32'h0100);
    wr(8'h00, 32'h0022, 2'h0);
    ext[2] <= 16'h0000;
    tick(6);
    chk({16'h0, dac_out[2]}, 32'h0100);
    wr(8'h08, 32'h0040, 2'h0);
    tick(4);
    chk({16'h0, dac_out[2]}, 32'h0040);
    wr(8'h00, 32'h0122, 2'h0);
    tick(4);
    rd(8'h08, 32'h0, 2'h0);
    chk({16'h0, dac_out[2]}, 32'h0);
    // section 1: feedback, plant loops channel 3 back to source 0
    wr(8'h54, 32'h0080, 2'h0);
    wr(8'h58, 32'h0100, 2'h0);
    wr(8'h40, 32'h0008, 2'h0);
    wr(8'h54, 32'h0100, 2'h0);
    rd(8'h58, 32'h0200, 2'h0);
    wr(8'h40, 32'h0000, 2'h0);
    wr(8'h54, 32'h0000, 2'h0);
    wr(8'h58, 32'h0100, 2'h0);
    wr(8'h4C, 32'h0000, 2'h0);
    wr(8'h50, 32'h0800, 2'h0);
    wr(8'h5C, 32'h0400, 2'h0);
    wr(8'h44, 32'h0300, 2'h0);
    loop_on <= 1'b1;
    wr(8'h40, 32'h0021, 2'h0);
    tick(600);
    chk_range(dac_out[3], 16'h03F0, 16'h0410);
    wr(8'h5C, 32'h0200, 2'h0);
    wr(8'h40, 32'h0025, 2'h0);
    tick(300);
    chk({16'h0, dac_out[3]}, 32'h0800);
    rd(8'h40, 32'h00010025, 2'h0);
    wr(8'h40, 32'h0021, 2'h0);
    tick(12);
    chk_range(dac_out[3], 16'h0000, 16'h07FF);
    wr(8'h68, 32'h0100, 2'h0);
    wr(8'h40, 32'h0031, 2'h0);
    tick(100);
    lo = 16'hFFFF;
    hi = 16'h0000;
    repeat (40) begin
      @(posedge aclk);
      if (dac_out[3] < lo) lo = dac_out[3];
      if (dac_out[3] > hi) hi = dac_out[3];
    end
    chk_range(hi - lo, 16'h0020, 16'hFFFF);
    wrap_up();
  end
endmodule : testbench
